// ---- air_host_model.sv ----
// Behavioural serial bus host driving the block's clock and data pins.
`timescale 1ns/1ps
module air_host_model (
    input  wire logic clk,
    input  wire logic sdaOe,
    output logic      sclPin,
    output logic      sdaPin
);
    logic sdaDrv;
    ////////////////////////////////////////
    // Open drain with pull-up: high unless a side pulls low.
    assign sdaPin = sdaDrv && !sdaOe;
    // The clock idles high and moves only inside frames.
    initial
    begin
        sclPin = 1'b1;
        sdaDrv = 1'b1;
    end
    // Six cycles a phase leaves margin over the pin synchroniser.
    task automatic w;
        repeat (6) @(posedge clk);
    endtask : w
    // Start, also repeated: data falls while the clock is high.
    task automatic start;
        sdaDrv <= 1'b1;
        w();
        sclPin <= 1'b1;
        w();
        sdaDrv <= 1'b0;
        w();
        sclPin <= 1'b0;
        w();
    endtask : start
    // Stop: data rises while the clock is high.
    task automatic stop;
        sdaDrv <= 1'b0;
        w();
        sclPin <= 1'b1;
        w();
        sdaDrv <= 1'b1;
        w();
    endtask : stop
    // Data changes two or more cycles after the fall, so never next to an edge.
    task automatic bitx(input logic b, output logic r);
        sdaDrv <= b;
        w();
        sclPin <= 1'b1;
        repeat (3) @(posedge clk);
        r = sdaPin;
        repeat (3) @(posedge clk);
        sclPin <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : bitx
    // A byte, high bit first, then a released ninth bit.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(tx[i], r);
            rx[i] = r;
        end
        bitx(1'b1, r);
        ack = !r;
    endtask : xfer
endmodule : air_host_model

// ---- air_pin_sync.sv ----
// Pin synchroniser and bus condition detector for the serial clock and data.
`timescale 1ns/1ps
module air_pin_sync
    import air_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sclPin,
    input  wire logic sdaPin,
    output logic      sdaIn,
    output logic      sclRise,
    output logic      sclFall,
    output logic      busStart,
    output logic      busStop
);

    typedef struct packed {
        logic sclS1;
        logic sclS2;
        logic sclD;
        logic sdaS1;
        logic sdaS2;
        logic sdaD;
    } air_sync_s;

    air_sync_s r_r;
    air_sync_s r_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // First stages feed only the second stages; edges look at stage two on.
    always_comb
    begin
        r_nxt       = r_r;
        r_nxt.sclS1 = sclPin;
        r_nxt.sclS2 = r_r.sclS1;
        r_nxt.sclD  = r_r.sclS2;
        r_nxt.sdaS1 = sdaPin;
        r_nxt.sdaS2 = r_r.sdaS1;
        r_nxt.sdaD  = r_r.sdaS2;
    end

    // Idle bus is high, so reset to ones to avoid a false condition.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r_r <= '1;
        else
            r_r <= r_nxt;
    end

    // Start and stop need the clock high in both samples around the edge.
    assign sdaIn    = r_r.sdaS2;
    assign sclRise  = r_r.sclS2 & ~r_r.sclD;
    assign sclFall  = ~r_r.sclS2 & r_r.sclD;
    assign busStart = r_r.sclS2 & r_r.sclD & r_r.sdaD & ~r_r.sdaS2;
    assign busStop  = r_r.sclS2 & r_r.sclD & ~r_r.sdaD & r_r.sdaS2;

endmodule : air_pin_sync

// ---- air_pkg.sv ----
// Shared constants and types for the accessory interrupt and timing registers.
package air_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial bus addressing.
    localparam logic [6:0] SLAVE_ADDR    = 7'h25;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] ADDR_FLAGS1   = 8'h03;
    localparam logic [7:0] ADDR_FLAGS2   = 8'h04;
    localparam logic [7:0] ADDR_MASK1    = 8'h05;
    localparam logic [7:0] ADDR_MASK2    = 8'h06;
    localparam logic [7:0] ADDR_IDCODE   = 8'h07;
    localparam logic [7:0] ADDR_TIMING1  = 8'h08;
    localparam logic [7:0] ADDR_TIMING2  = 8'h09;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0] RST_FLAGS1    = 8'h00;
    localparam logic [7:0] RST_FLAGS2    = 8'h00;
    localparam logic [7:0] RST_MASK1     = 8'h00;
    localparam logic [7:0] RST_MASK2     = 8'h00;
    localparam logic [7:0] RST_IDCODE    = 8'h1f;
    localparam logic [7:0] RST_TIMING1   = 8'h00;
    localparam logic [7:0] RST_TIMING2   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Field layouts.
    localparam logic [7:0] FLAGS2_USED   = 8'h1e;
    localparam logic [7:0] IDCODE_USED   = 8'h1f;
    localparam int         UPPER_LSB     = 4;
    localparam int         FIELD_W       = 4;
    localparam int         FLAG2_RECOVER = 4;
    localparam int         FLAG2_STUCK   = 3;
    localparam int         FLAG2_IDCHG   = 2;
    localparam int         FLAG2_RESATT  = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine states.
    typedef enum logic [2:0] {
        AIR_IDLE,
        AIR_ADDR,
        AIR_ACK_ADDR,
        AIR_WR_BYTE,
        AIR_ACK_WR,
        AIR_RD_BYTE,
        AIR_RD_ACK
    } air_state_e;

endpackage : air_pkg

// ---- air_regs.sv ----
// Interrupt flag, mask, level code and timing registers behind a serial slave.
//
// Function
// RL1: Second flag register at 04H, resets zero, cleared when the host reads it.
// RL2: Second flags: bit4 stuck recovered, bit3 stuck, bit2 level change, bit1 attach.
// RL3: First mask at 05H resets zero; a one suppresses the matching first event.
// RL4: Second mask at 06H resets zero; bits 4..1 mask the second-register events.
// RL5: Reserved bits 7..5 and 0 of second flags and mask; host writes zero.
// RL6: Register 07H shows the read-only 5-bit level code, reset 1FH.
// RL7: Upper field of 08H selects key press duration threshold, reset zero.
// RL8: Lower field of 08H selects level detection time before acceptance.
// RL9: 09H resets zero; upper field wait time, lower field long press threshold.
// RL10: First flag register at 03H, read-to-clear, reset zero, eight event bits.
// RL11: Interrupt output asserted while any unmasked flag is set, released after clear.
`timescale 1ns/1ps
module air_regs
    import air_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sclPin,
    input  wire logic       sdaPin,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic [7:0] eventsFirst,
    input  wire logic [3:0] eventsSecond,
    input  wire logic       idLevelValid,
    input  wire logic [4:0] idLevelCode,
    output logic [3:0]      keyPressTime,
    output logic [3:0]      idDetectTime,
    output logic [3:0]      switchWaitTime,
    output logic [3:0]      longKeyPressTime,
    output logic            irqOut_n
);

    ////////////////////////////////////////////////////////////////////////////
    // State of the whole block.
    typedef struct packed {
        air_state_e st;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic       rw;
        logic       ptrPhase;
        logic       acked;
        logic [7:0] ptr;
        logic       oe;
        logic [7:0] flags1;
        logic [7:0] flags2;
        logic [7:0] mask1;
        logic [7:0] mask2;
        logic [7:0] idCode;
        logic [7:0] timing1;
        logic [7:0] timing2;
        logic       irqPend;
    } air_regs_s;

    air_regs_s r_r;
    air_regs_s r_nxt;

    logic sdaIn;
    logic sclRise;
    logic sclFall;
    logic busStart;
    logic busStop;

    ////////////////////////////////////////////////////////////////////////////
    // Pin conditioning.
    air_pin_sync u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .sclPin   (sclPin),
        .sdaPin   (sdaPin),
        .sdaIn    (sdaIn),
        .sclRise  (sclRise),
        .sclFall  (sclFall),
        .busStart (busStart),
        .busStop  (busStop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; reserved bits and unmapped offsets read as zero.
    function automatic logic [7:0] reg_read(
        input logic [7:0] a,
        input air_regs_s  s
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_FLAGS1:  v = s.flags1;
            ADDR_FLAGS2:  v = s.flags2 & FLAGS2_USED;
            ADDR_MASK1:   v = s.mask1;
            ADDR_MASK2:   v = s.mask2 & FLAGS2_USED;
            ADDR_IDCODE:  v = s.idCode & IDCODE_USED;
            ADDR_TIMING1: v = s.timing1;
            ADDR_TIMING2: v = s.timing2;
            default:      v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine, register writes, flag capture and interrupt level.
    always_comb
    begin
        logic       load;
        logic       clr1;
        logic       clr2;
        logic [7:0] set2;
        load  = 1'b0;
        clr1  = 1'b0;
        clr2  = 1'b0;
        set2  = 8'h00;
        r_nxt = r_r;
        case (r_r.st)
            AIR_IDLE:
            begin
                r_nxt.oe = 1'b0;
            end
            AIR_ADDR, AIR_WR_BYTE:
            begin
                if (sclRise)
                begin
                    r_nxt.shift  = {r_r.shift[6:0], sdaIn};
                    r_nxt.bitCnt = r_r.bitCnt + 4'h1;
                end
                else if (sclFall && r_r.bitCnt == BITS_PER_BYTE)
                begin
                    r_nxt.bitCnt = 4'h0;
                    if (r_r.st == AIR_ADDR)
                    begin
                        // A foreign address drops us off the bus until next start.
                        if (r_r.shift[7:1] == SLAVE_ADDR)
                        begin
                            r_nxt.rw = r_r.shift[0];
                            r_nxt.oe = 1'b1;
                            r_nxt.st = AIR_ACK_ADDR;
                        end
                        else
                            r_nxt.st = AIR_IDLE;
                    end
                    else
                    begin
                        r_nxt.oe = 1'b1;
                        r_nxt.st = AIR_ACK_WR;
                        if (r_r.ptrPhase)
                        begin
                            r_nxt.ptr      = r_r.shift;
                            r_nxt.ptrPhase = 1'b0;
                        end
                        else
                        begin
                            // Flag and level code offsets ignore writes.
                            case (r_r.ptr)
                                ADDR_MASK1:   r_nxt.mask1 = r_r.shift; // see RL3
                                ADDR_MASK2:   r_nxt.mask2 =
                                    r_r.shift & FLAGS2_USED; // see RL4 see RL5
                                ADDR_TIMING1: r_nxt.timing1 = r_r.shift; // see RL7
                                ADDR_TIMING2: r_nxt.timing2 = r_r.shift; // see RL9
                                default:      r_nxt.ptr = r_r.ptr;
                            endcase
                            r_nxt.ptr = r_r.ptr + 8'h01;
                        end
                    end
                end
            end
            AIR_ACK_ADDR:
            begin
                if (sclFall)
                begin
                    if (r_r.rw)
                        load = 1'b1;
                    else
                    begin
                        r_nxt.oe       = 1'b0;
                        r_nxt.ptrPhase = 1'b1;
                        r_nxt.st       = AIR_WR_BYTE;
                    end
                end
            end
            AIR_ACK_WR:
            begin
                if (sclFall)
                begin
                    r_nxt.oe = 1'b0;
                    r_nxt.st = AIR_WR_BYTE;
                end
            end
            AIR_RD_BYTE:
            begin
                if (sclRise)
                    r_nxt.bitCnt = r_r.bitCnt + 4'h1;
                else if (sclFall)
                begin
                    if (r_r.bitCnt == BITS_PER_BYTE)
                    begin
                        r_nxt.oe     = 1'b0;
                        r_nxt.bitCnt = 4'h0;
                        r_nxt.st     = AIR_RD_ACK;
                    end
                    else
                    begin
                        r_nxt.shift = {r_r.shift[6:0], 1'b0};
                        r_nxt.oe    = ~r_r.shift[6];
                    end
                end
            end
            AIR_RD_ACK:
            begin
                if (sclRise)
                    r_nxt.acked = ~sdaIn;
                else if (sclFall)
                begin
                    if (r_r.acked)
                        load = 1'b1;
                    else
                        r_nxt.st = AIR_IDLE;
                end
            end
            default:
            begin
                r_nxt.st = AIR_IDLE;
                r_nxt.oe = 1'b0;
            end
        endcase

        // Fetch a byte for the host; reading a flag register empties it.
        if (load)
        begin
            r_nxt.shift  = reg_read(r_r.ptr, r_r);
            r_nxt.oe     = ~r_nxt.shift[7];
            r_nxt.bitCnt = 4'h0;
            r_nxt.st     = AIR_RD_BYTE;
            r_nxt.ptr    = r_r.ptr + 8'h01;
            clr1         = (r_r.ptr == ADDR_FLAGS1); // see RL10
            clr2         = (r_r.ptr == ADDR_FLAGS2); // see RL1
        end

        // A start restarts the engine from anywhere; a stop idles it.
        if (busStart)
        begin
            r_nxt.st     = AIR_ADDR;
            r_nxt.bitCnt = 4'h0;
            r_nxt.oe     = 1'b0;
        end
        else if (busStop)
        begin
            r_nxt.st = AIR_IDLE;
            r_nxt.oe = 1'b0;
        end

        // Events landing in the clearing cycle survive: set wins over clear.
        set2[FLAG2_RECOVER] = eventsSecond[3]; // see RL2
        set2[FLAG2_STUCK]   = eventsSecond[2]; // see RL2
        set2[FLAG2_IDCHG]   = eventsSecond[1]; // see RL2
        set2[FLAG2_RESATT]  = eventsSecond[0]; // see RL2
        r_nxt.flags1 = (clr1 ? 8'h00 : r_r.flags1)
                     | (eventsFirst & ~r_r.mask1); // see RL10 see RL3
        r_nxt.flags2 = (clr2 ? 8'h00 : r_r.flags2)
                     | (set2 & ~r_r.mask2 & FLAGS2_USED); // see RL1 see RL4

        // The level code is a measurement, so it follows the detection engine only.
        if (idLevelValid)
            r_nxt.idCode = {3'b000, idLevelCode}; // see RL6

        // Masks are applied again so a late mask also quiets a pending flag.
        r_nxt.irqPend = |((r_nxt.flags1 & ~r_nxt.mask1)
                        | (r_nxt.flags2 & ~r_nxt.mask2)); // see RL11
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset loads the power-on value of every register.
    // Only constants appear here, so the reset path stays free of logic.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_r          <= '0;
            r_r.st       <= AIR_IDLE;
            r_r.flags1   <= RST_FLAGS1;  // see RL10
            r_r.flags2   <= RST_FLAGS2;  // see RL1
            r_r.mask1    <= RST_MASK1;   // see RL3
            r_r.mask2    <= RST_MASK2;   // see RL4
            r_r.idCode   <= RST_IDCODE;  // see RL6
            r_r.timing1  <= RST_TIMING1; // see RL7
            r_r.timing2  <= RST_TIMING2; // see RL9
        end
        else
            r_r <= r_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; the data pin is open drain and only ever pulled low.
    // Timing fields go straight out; the detection engine decodes them.
    assign sdaOut           = 1'b0;
    assign sdaOe            = r_r.oe;
    assign keyPressTime     = r_r.timing1[UPPER_LSB +: FIELD_W]; // see RL7
    assign idDetectTime     = r_r.timing1[0 +: FIELD_W];         // see RL8
    assign switchWaitTime   = r_r.timing2[UPPER_LSB +: FIELD_W]; // see RL9
    assign longKeyPressTime = r_r.timing2[0 +: FIELD_W];         // see RL9
    assign irqOut_n         = ~r_r.irqPend;                      // see RL11

endmodule : air_regs

// ---- air_regs_asserts.sv ----
// Port-level assertions for the interrupt and timing registers.
`timescale 1ns/1ps
module air_regs_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sclPin,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic [7:0] eventsFirst,
    input wire logic [3:0] eventsSecond,
    input wire logic [3:0] keyPressTime,
    input wire logic [3:0] idDetectTime,
    input wire logic [3:0] switchWaitTime,
    input wire logic [3:0] longKeyPressTime,
    input wire logic       irqOut_n
);
    wire logic [7:0] tim1 = {keyPressTime, idDetectTime};
    wire logic [7:0] tim2 = {switchWaitTime, longKeyPressTime};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Data may only move while the bus clock is low.
    sequence s_sclHigh;
        sclPin [*3];
    endsequence
    // A write lands as the acknowledge goes out.
    sequence s_ackSoon;
        !sclPin ##[0:1] sdaOe;
    endsequence
    property p_rstOut;
        $rose(rst_n) |-> irqOut_n && !sdaOe && tim1 == 8'h00 && tim2 == 8'h00;
    endproperty
    property p_sdaLow;
        sdaOut == 1'b0;
    endproperty
    property p_oeHigh;
        s_sclHigh |-> $stable(sdaOe);
    endproperty
    property p_oeLow;
        $changed(sdaOe) |-> !sclPin;
    endproperty
    property p_irqFall;
        $fell(irqOut_n) |-> $past(|eventsFirst || |eventsSecond);
    endproperty
    property p_irqRise;
        $rose(irqOut_n) |-> !sclPin;
    endproperty
    property p_tim1;
        $changed(tim1) |-> s_ackSoon;
    endproperty
    property p_tim2;
        $changed(tim2) |-> s_ackSoon;
    endproperty
    a_rstOut: assert property (p_rstOut)
        else $error("outputs wrong after reset");
    a_sdaLow: assert property (p_sdaLow)
        else $error("data output not low");
    a_oeHigh: assert property (p_oeHigh)
        else $error("data moved in clock high");
    a_oeLow: assert property (p_oeLow)
        else $error("data moved with clock high");
    a_irqFall: assert property (p_irqFall)
        else $error("interrupt without event");
    a_irqRise: assert property (p_irqRise)
        else $error("interrupt released off a read");
    a_tim1: assert property (p_tim1)
        else $error("timing 1 changed off a write");
    a_tim2: assert property (p_tim2)
        else $error("timing 2 changed off a write");
endmodule : air_regs_asserts

// ---- test_accessory_irq_timing_regs.sv ----
// Self-checking bench for the interrupt and timing registers.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module test_accessory_irq_timing_regs
    import air_pkg::*;
;
    logic       clk, rst_n, sclPin, sdaPin, sdaOut, sdaOe, irqOut_n;
    logic       idLevelValid;
    logic [7:0] eventsFirst;
    logic [3:0] eventsSecond, keyPressTime, idDetectTime;
    logic [3:0] switchWaitTime, longKeyPressTime;
    logic [4:0] idLevelCode;
    logic [7:0] rxJunk;
    logic       ackSeen;
    int         mismatches = 0;
    int         checked = 0;
    logic [7:0] rwAddr [4] = '{8'h05, 8'h06, 8'h08, 8'h09};
    logic [7:0] rwData [4] = '{8'ha5, 8'h1e, 8'ha5, 8'h3c};
    logic [7:0] rstVal [6] = '{8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00};
    air_regs dut_u (
        .clk, .rst_n, .sclPin, .sdaPin, .sdaOut, .sdaOe, .eventsFirst,
        .eventsSecond, .idLevelValid, .idLevelCode, .keyPressTime,
        .idDetectTime, .switchWaitTime, .longKeyPressTime, .irqOut_n
    );
    air_host_model host_u (.clk, .sdaOe, .sclPin, .sdaPin);
    ////////////////////////////////////////
    // Write one register: address, pointer, data, all acknowledged.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] rx;
        logic k0, k1, k2;
        host_u.start();
        host_u.xfer({SLAVE_ADDR, 1'b0}, rx, k0);
        host_u.xfer(a, rx, k1);
        host_u.xfer(d, rx, k2);
        host_u.stop();
        `CHK({k0, k1, k2}, 3'h7)
    endtask : wr
    // Read one register; the host ends with a refusal of more data.
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] rx;
        logic [7:0] d;
        logic k0, k1, k2, k3;
        host_u.start();
        host_u.xfer({SLAVE_ADDR, 1'b0}, rx, k0);
        host_u.xfer(a, rx, k1);
        host_u.start();
        host_u.xfer({SLAVE_ADDR, 1'b1}, rx, k2);
        host_u.xfer(8'hff, d, k3);
        host_u.stop();
        `CHK({k0, k1, k2, k3}, 4'he)
        `CHK(d, e)
    endtask : rdChk
    // One-cycle event strobes, then time for the flags to land.
    task automatic pulse(input logic [7:0] f, input logic [3:0] s,
                         input logic v);
        eventsFirst <= f;
        eventsSecond <= s;
        idLevelValid <= v;
        @(posedge clk);
        eventsFirst <= 8'h00;
        eventsSecond <= 4'h0;
        idLevelValid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // A hung bus cannot stall the run past this bound.
    initial
    begin
        repeat (90000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    initial
    begin
        rst_n = 1'b0;
        eventsFirst = 8'h00;
        eventsSecond = 4'h0;
        idLevelValid = 1'b0;
        idLevelCode = 5'h00;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({keyPressTime, idDetectTime}, 8'h00)
        `CHK({switchWaitTime, longKeyPressTime}, 8'h00)
        for (int i = 0; i < 6; i++)
            rdChk(8'h04 + 8'(i), rstVal[i]);
        $display("reset test done");
        // Reserved bits are written as zero by the host.
        for (int i = 0; i < 4; i++)
            wr(rwAddr[i], rwData[i]);
        for (int i = 0; i < 4; i++)
            rdChk(rwAddr[i], rwData[i]);
        `CHK({keyPressTime, idDetectTime}, 8'ha5)
        `CHK({switchWaitTime, longKeyPressTime}, 8'h3c)
        pulse(8'h00, 4'hf, 1'b0);
        `CHK(irqOut_n, 1'b1)
        rdChk(ADDR_FLAGS2, 8'h00);
        pulse(8'ha5, 4'h0, 1'b0);
        `CHK(irqOut_n, 1'b1)
        pulse(8'h5a, 4'h0, 1'b0);
        `CHK(irqOut_n, 1'b0)
        rdChk(ADDR_FLAGS1, 8'h5a);
        `CHK(irqOut_n, 1'b1)
        rdChk(ADDR_FLAGS1, 8'h00);
        wr(ADDR_MASK1, 8'h00);
        wr(ADDR_MASK2, 8'h00);
        $display("mask test done");
        // Each second event alone, then cleared by a single read.
        for (int i = 0; i < 4; i++)
        begin
            pulse(8'h00, 4'(1 << i), 1'b0);
            `CHK(irqOut_n, 1'b0)
            rdChk(ADDR_FLAGS2, 8'(2 << i));
            rdChk(ADDR_FLAGS2, 8'h00);
            `CHK(irqOut_n, 1'b1)
        end
        $display("flag test done");
        idLevelCode <= 5'h0a;
        pulse(8'h00, 4'h0, 1'b1);
        rdChk(ADDR_IDCODE, 8'h0a);
        wr(ADDR_IDCODE, 8'h00);
        rdChk(ADDR_IDCODE, 8'h0a);
        rdChk(8'h20, 8'h00);
        // A foreign address is neither acknowledged nor acted on.
        host_u.start();
        host_u.xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, rxJunk, ackSeen);
        host_u.stop();
        `CHK(ackSeen, 1'b0)
        rdChk(ADDR_TIMING1, 8'ha5);
        $display("level code test done");
        stop_test();
    end
endmodule : test_accessory_irq_timing_regs
bind air_regs air_regs_asserts chk_u (
    .clk, .rst_n, .sclPin, .sdaOut, .sdaOe, .eventsFirst, .eventsSecond,
    .keyPressTime, .idDetectTime, .switchWaitTime, .longKeyPressTime,
    .irqOut_n
);
